// *** rtl/sap_pkg.sv ***
// constants and types for the converter control and parallel read port
// Summary of operation
// RULE_01: a falling edge on conv_start_n starts a new conversion.
// RULE_02: conv_start_n and rd_n are honoured only while cs_n is low.
// RULE_03: data lines are driven only while rd_n and cs_n are both low.
// RULE_04: busy_n stays low for the whole conversion, then returns high.
// RULE_05: the result is valid by the rising edge of busy_n.
// RULE_06: host releases conv_start_n within 400ns or after busy_n rises.
// RULE_07: sleep_n low enters deepest power-down and drops reference_ready.
// RULE_08: reference_ready rises after the reference settles; host waits for it.
// RULE_09: nap_n low powers down all but reference; host waits 620ns after release.
// RULE_10: two-byte upper read puts bits 11..8 on lines 3..0, lines 7..4 low.
// RULE_11: two-byte lower read puts bits 7..0 on lines 7..0 within 100ns.
// RULE_12: host settles upper_byte_sel 10ns around the read strobe.
// RULE_13: two-byte format is straight binary unipolar, offset binary bipolar.
// RULE_14: bipolar zero step is 7FF/800 offset binary, 000/FFF two's complement.
// RULE_15: single-word format drives twelve lines, line eleven carries the MSB.
// RULE_16: conversion start clears the approximation register; starts ignored while busy.
// RULE_17: last result stays readable until the next conversion completes.
// RULE_18: starts are ignored in sleep, in nap, or while reference_ready is low.
package sap_pkg;

  // ------------------------------------------------------------
  // clock and timing
  // ------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 25;
  localparam int BIT_SLOT_NS = 500; // one bit decision, first lands after 500ns
  localparam int BIT_SLOT_CYC = (BIT_SLOT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int REF_SETTLE_NS = 4_200_000;
  localparam int REF_SETTLE_CYC = (REF_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int LOW_BYTE_VALID_NS = 100;
  localparam int LOW_BYTE_VALID_CYC = LOW_BYTE_VALID_NS / CLK_PERIOD_NS;

  // ------------------------------------------------------------
  // data widths and layout
  // ------------------------------------------------------------
  localparam int RES_W = 12;
  localparam int BYTE_W = 8;
  localparam int NIB_W = 4;
  localparam logic [RES_W-1:0] RESULT_RST = 12'h000;
  localparam logic [RES_W-1:0] OE_WORD = 12'hFFF;
  localparam logic [RES_W-1:0] OE_BYTE = 12'h0FF;

  // ------------------------------------------------------------
  // synchroniser vector layout
  // ------------------------------------------------------------
  localparam int SY_W = 8;
  localparam int SY_CS = 0;
  localparam int SY_CONV = 1;
  localparam int SY_RD = 2;
  localparam int SY_UBS = 3;
  localparam int SY_SLEEP = 4;
  localparam int SY_NAP = 5;
  localparam int SY_TWOB = 6;
  localparam int SY_BIP = 7;
  localparam logic [SY_W-1:0] SY_RST = 8'h37; // strobes, sleep_n and nap_n idle high; byte select and format modes low

  // ------------------------------------------------------------
  // converter sequencer states
  // ------------------------------------------------------------
  typedef enum logic [0:0] {
    SAP_IDLE = 1'b0,
    SAP_CONV = 1'b1
  } sap_state_type;

endpackage

// *** rtl/sap_sync.sv ***
// two flip-flop synchroniser for a vector of pin inputs
`timescale 1ns/10ps
module sap_sync #(
  parameter int W = 8,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);

  logic [W-1:0] meta_q;
  logic [W-1:0] sync_q;

  // first stage feeds only the second stage
  always_ff @(posedge clk) begin
    if (!rstn) begin
      meta_q <= RST_VAL;
      sync_q <= RST_VAL;
    end else begin
      meta_q <= din;
      sync_q <= meta_q;
    end
  end

  assign dout = sync_q;

endmodule

// *** rtl/sap_top.sv ***
// converter sequencer, power modes and parallel read port
`timescale 1ns/10ps
module sap_top #(
  parameter int BIT_SLOT_CYC = sap_pkg::BIT_SLOT_CYC,
  parameter int REF_SETTLE_CYC = sap_pkg::REF_SETTLE_CYC
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic cs_n,
  input wire logic conv_start_n,
  input wire logic rd_n,
  input wire logic upper_byte_sel,
  input wire logic sleep_n,
  input wire logic nap_n,
  input wire logic two_byte_mode,
  input wire logic bipolar_mode,
  input wire logic comp_hi,
  output logic busy_n,
  output logic reference_ready,
  output logic [sap_pkg::RES_W-1:0] data_out,
  output logic [sap_pkg::RES_W-1:0] data_oe,
  output logic [sap_pkg::RES_W-1:0] dac_code,
  output logic sleep_pwrdn,
  output logic nap_pwrdn
);

  // ------------------------------------------------------------
  // elaboration checks
  // ------------------------------------------------------------
  if (BIT_SLOT_CYC < 2 || BIT_SLOT_CYC > 255) begin : g_bad_slot
    $error("BIT_SLOT_CYC must lie in 2..255");
  end
  if (REF_SETTLE_CYC < 1) begin : g_bad_ref
    $error("REF_SETTLE_CYC must be at least 1");
  end

  // derived sizes and fixed trial codes
  localparam int RW = sap_pkg::RES_W;
  localparam int CW = $clog2(REF_SETTLE_CYC + 1);
  localparam logic [CW-1:0] REF_LAST = CW'(REF_SETTLE_CYC);
  localparam logic [7:0] SLOT_LAST = 8'(BIT_SLOT_CYC - 1);
  localparam logic [RW-1:0] MSB_TRIAL = 12'h800;
  localparam logic [3:0] TOP_BIT = 4'hB;

  // ------------------------------------------------------------
  // pin synchronisers
  // ------------------------------------------------------------
  logic [sap_pkg::SY_W-1:0] pins;
  logic [sap_pkg::SY_W-1:0] sy;

  // every pin except clk, rstn and comp_hi passes two flip-flops before any logic reads it
  assign pins = {bipolar_mode, two_byte_mode, nap_n, sleep_n, upper_byte_sel, rd_n,
                 conv_start_n, cs_n};

  sap_sync #(
    .W(sap_pkg::SY_W),
    .RST_VAL(sap_pkg::SY_RST)
  ) u_sync (
    .clk(clk),
    .rstn(rstn),
    .din(pins),
    .dout(sy)
  );

  wire s_cs_n = sy[sap_pkg::SY_CS];
  wire s_conv_n = sy[sap_pkg::SY_CONV];
  wire s_rd_n = sy[sap_pkg::SY_RD];
  wire s_ubs = sy[sap_pkg::SY_UBS];
  wire s_sleep_n = sy[sap_pkg::SY_SLEEP];
  wire s_nap_n = sy[sap_pkg::SY_NAP];
  wire s_two_byte = sy[sap_pkg::SY_TWOB];
  wire s_bipolar = sy[sap_pkg::SY_BIP];

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  sap_pkg::sap_state_type state_q, state_d;
  logic conv_prev_q;
  logic [7:0] slot_q, slot_d;
  logic [3:0] bit_q, bit_d;
  logic [RW-1:0] sar_q, sar_d;
  logic [RW-1:0] result_q, result_d;
  logic [CW-1:0] ref_cnt_q, ref_cnt_d;
  logic ref_rdy_q;
  logic busy_n_q;
  logic [RW-1:0] data_q, data_d;
  logic [RW-1:0] oe_q, oe_d;
  logic sleep_pd_q;
  logic nap_pd_q;

  // ------------------------------------------------------------
  // start detection and qualification
  // ------------------------------------------------------------
  wire start_fall = conv_prev_q & ~s_conv_n & ~s_cs_n; // RULE_01 RULE_02
  wire powered = s_sleep_n & s_nap_n;
  wire can_start = (state_q == sap_pkg::SAP_IDLE) & powered & ref_rdy_q; // RULE_16 RULE_18
  wire start_go = start_fall & can_start;

  // ------------------------------------------------------------
  // successive approximation step
  // ------------------------------------------------------------
  wire slot_end = (slot_q == SLOT_LAST);
  wire last_bit = (bit_q == 4'h0);
  wire [RW-1:0] trial = MSB_TRIAL >> (TOP_BIT - bit_q);
  wire [RW-1:0] sar_keep = comp_hi ? sar_q : (sar_q & ~trial);
  wire [RW-1:0] sar_next = last_bit ? sar_keep : (sar_keep | (trial >> 1));

  // sequencer: sleep or nap abandons a conversion and keeps the old result
  always_comb begin
    state_d = state_q;
    slot_d = slot_q;
    bit_d = bit_q;
    sar_d = sar_q;
    result_d = result_q;
    case (state_q)
      sap_pkg::SAP_IDLE: begin
        if (start_go) begin
          state_d = sap_pkg::SAP_CONV;
          sar_d = MSB_TRIAL; // RULE_16
          bit_d = TOP_BIT;
          slot_d = 8'h00;
        end
      end
      sap_pkg::SAP_CONV: begin
        if (!powered) begin
          state_d = sap_pkg::SAP_IDLE;
        end else if (slot_end) begin
          slot_d = 8'h00;
          sar_d = sar_next;
          bit_d = bit_q - 4'h1;
          if (last_bit) begin
            state_d = sap_pkg::SAP_IDLE;
            result_d = sar_keep; // RULE_05 RULE_17
          end
        end else begin
          slot_d = slot_q + 8'h01;
        end
      end
      default: begin
        state_d = sap_pkg::SAP_IDLE;
      end
    endcase
  end

  // ------------------------------------------------------------
  // reference settling after sleep
  // ------------------------------------------------------------
  // counter restarts in sleep and parks at its last value once settled
  assign ref_cnt_d = !s_sleep_n ? '0 :
                     (ref_cnt_q == REF_LAST) ? ref_cnt_q :
                     ref_cnt_q + 1'b1; // RULE_08

  // ------------------------------------------------------------
  // output coding and read port
  // ------------------------------------------------------------
  // coding reads the next result so the data registers load on the same edge
  // as busy_n rises; a host latching on that edge sees the new word
  wire [RW-1:0] twos = {~result_d[RW-1], result_d[RW-2:0]}; // RULE_14
  wire [RW-1:0] coded = (s_bipolar & ~s_two_byte) ? twos : result_d; // RULE_05 RULE_13
  wire [RW-1:0] hi_byte = {{(RW-sap_pkg::NIB_W){1'b0}}, coded[RW-1:sap_pkg::BYTE_W]}; // RULE_10
  wire [RW-1:0] lo_byte = {{(RW-sap_pkg::BYTE_W){1'b0}}, coded[sap_pkg::BYTE_W-1:0]}; // RULE_11
  wire [RW-1:0] byte_sel = s_ubs ? hi_byte : lo_byte;
  wire drive = ~s_cs_n & ~s_rd_n; // RULE_02 RULE_03
  assign data_d = s_two_byte ? byte_sel : coded; // RULE_15
  assign oe_d = !drive ? '0 : (s_two_byte ? sap_pkg::OE_BYTE : sap_pkg::OE_WORD); // RULE_03

  // sequencer registers
  always_ff @(posedge clk) begin
    if (!rstn) begin
      state_q <= sap_pkg::SAP_IDLE;
      slot_q <= 8'h00;
      bit_q <= 4'h0;
      sar_q <= sap_pkg::RESULT_RST;
      result_q <= sap_pkg::RESULT_RST;
      conv_prev_q <= 1'b1;
    end else begin
      state_q <= state_d;
      slot_q <= slot_d;
      bit_q <= bit_d;
      sar_q <= sar_d;
      result_q <= result_d;
      conv_prev_q <= s_conv_n;
    end
  end

  // status and power registers
  always_ff @(posedge clk) begin
    if (!rstn) begin
      ref_cnt_q <= '0;
      ref_rdy_q <= 1'b0;
      busy_n_q <= 1'b1;
      sleep_pd_q <= 1'b0;
      nap_pd_q <= 1'b0;
    end else begin
      ref_cnt_q <= ref_cnt_d;
      ref_rdy_q <= s_sleep_n & (ref_cnt_q == REF_LAST); // RULE_07 RULE_08
      busy_n_q <= (state_d != sap_pkg::SAP_CONV); // RULE_04
      sleep_pd_q <= ~s_sleep_n; // RULE_07
      nap_pd_q <= ~s_nap_n & s_sleep_n; // RULE_09
    end
  end

  // read port registers
  always_ff @(posedge clk) begin
    if (!rstn) begin
      data_q <= '0;
      oe_q <= '0;
    end else begin
      data_q <= data_d;
      oe_q <= oe_d;
    end
  end

  assign busy_n = busy_n_q;
  assign reference_ready = ref_rdy_q;
  assign data_out = data_q;
  assign data_oe = oe_q;
  assign dac_code = sar_q;
  assign sleep_pwrdn = sleep_pd_q;
  assign nap_pwrdn = nap_pd_q;

endmodule

// *** verification/sap_cmp_model.sv ***
// comparator model standing in for the analog side of the converter
`timescale 1ns/10ps
module sap_cmp_model (
  input wire logic [11:0] dac_code,
  input wire logic [11:0] level,
  output logic comp_hi
);
  // keep the trial bit while the trial code does not exceed the held level
  assign comp_hi = (dac_code <= level);
endmodule

// *** verification/sap_top_sva.sv ***
// assertion checker for the converter control and read port
`timescale 1ns/10ps
module sap_top_sva #(
  parameter int BIT_SLOT_CYC = 2,
  parameter int REF_SETTLE_CYC = 5
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic cs_n,
  input wire logic conv_start_n,
  input wire logic rd_n,
  input wire logic upper_byte_sel,
  input wire logic sleep_n,
  input wire logic nap_n,
  input wire logic two_byte_mode,
  input wire logic bipolar_mode,
  input wire logic comp_hi,
  input wire logic busy_n,
  input wire logic reference_ready,
  input wire logic [11:0] data_out,
  input wire logic [11:0] data_oe,
  input wire logic [11:0] dac_code,
  input wire logic sleep_pwrdn,
  input wire logic nap_pwrdn
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  localparam int CONV = 12 * BIT_SLOT_CYC;
  logic [8:0] cnt_q;
  // ----------------------------------------------------------
  // busy low-time counter and properties
  // ----------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rstn || busy_n)
      cnt_q <= 9'h000;
    else
      cnt_q <= cnt_q + 9'h001;
  end
  oe_gate_a:
    assert property (data_oe != 12'h000 |-> !$past(cs_n, 3) && !$past(rd_n, 3))
    else $error("data lines driven without a read");
  oe_width_a:
    assert property (data_oe != 12'h000 |->
      data_oe == ($past(two_byte_mode, 3) ? 12'h0FF : 12'hFFF))
    else $error("wrong set of data lines driven");
  busy_len_a:
    assert property ($rose(busy_n) && $past(sleep_n, 3) && $past(nap_n, 3) |-> cnt_q == CONV)
    else $error("conversion length wrong");
  start_ok_a:
    assert property ($fell(busy_n) |-> !$past(cs_n, 3) && !$past(conv_start_n, 3) &&
      $past(conv_start_n, 4) && $past(reference_ready) && $past(sleep_n, 3) && $past(nap_n, 3))
    else $error("conversion began without a legal start");
  dac_clear_a:
    assert property ($fell(busy_n) |-> dac_code == 12'h800)
    else $error("trial code not cleared at start");
  no_restart_a:
    assert property (!busy_n && !$past(busy_n) && $changed(dac_code) |-> dac_code != 12'h800)
    else $error("conversion restarted while busy");
  sleep_ref_a:
    assert property (!sleep_n |-> ##3 (!reference_ready && sleep_pwrdn))
    else $error("sleep did not drop reference ready");
  nap_dn_a:
    assert property ((!nap_n && sleep_n) [*4] |-> nap_pwrdn)
    else $error("nap did not power down");
  data_at_busy_a:
    assert property ($rose(busy_n) && data_oe == 12'hFFF && !$past(bipolar_mode, 3) &&
      $past(sleep_n, 3) && $past(nap_n, 3) |-> data_out == dac_code)
    else $error("result not on the data lines as busy rises");
  hi_nib_a:
    assert property (data_oe == 12'h0FF && $past(upper_byte_sel, 3) |-> data_out[7:4] == 4'h0)
    else $error("upper byte lines not low");
  cover property ($rose(busy_n));
  cover property (data_oe == 12'h0FF);
  cover property ($rose(reference_ready));
endmodule
bind sap_top sap_top_sva #(.BIT_SLOT_CYC(BIT_SLOT_CYC), .REF_SETTLE_CYC(REF_SETTLE_CYC))
  i_sap_top_sva (.*);

// *** verification/sap_top_test.sv ***
// self-checking bench for the converter control and read port
`timescale 1ns/10ps
module sap_top_test;
  logic clk = 1'b0, rstn = 1'b0, cs_n = 1'b1, cv_n = 1'b1, rd_n = 1'b1, ubs = 1'b0;
  logic sleep_n = 1'b1, nap_n = 1'b1, two_b = 1'b0, bip = 1'b0, comp_hi;
  logic busy_n, reference_ready, sleep_pwrdn, nap_pwrdn;
  logic [11:0] data_out, data_oe, dac_code, level = 12'h000;
  int n_errors = 0;
  int n_tests = 0;
  int low;
  // ----------------------------------------------------------
  // clock, design and comparator
  // ----------------------------------------------------------
  always #12.5 clk = ~clk;
  sap_top #(.BIT_SLOT_CYC(2), .REF_SETTLE_CYC(5)) i_sap_top (
    .clk(clk), .rstn(rstn), .cs_n(cs_n), .conv_start_n(cv_n), .rd_n(rd_n),
    .upper_byte_sel(ubs), .sleep_n(sleep_n), .nap_n(nap_n), .two_byte_mode(two_b),
    .bipolar_mode(bip), .comp_hi(comp_hi), .busy_n(busy_n),
    .reference_ready(reference_ready), .data_out(data_out), .data_oe(data_oe),
    .dac_code(dac_code), .sleep_pwrdn(sleep_pwrdn), .nap_pwrdn(nap_pwrdn));
  sap_cmp_model i_sap_cmp_model (.dac_code(dac_code), .level(level), .comp_hi(comp_hi));
  // compare and count
  task automatic chk(input logic [11:0] seen, input logic [11:0] exp, input string what);
    n_tests++;
    if (seen !== exp) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask
  // chip select first, short strobe, then bounded waits on busy
  task automatic convert(input logic [11:0] lv);
    level = lv;
    cs_n = 1'b0;
    cyc(1);
    cv_n = 1'b0;
    cyc(2);
    cv_n = 1'b1; // released inside the first bit slot
    low = 0;
    for (int i = 0; i < 40 && busy_n; i++) cyc(1);
    while (!busy_n && low < 60) begin
      cyc(1);
      low++;
    end
    chk(12'(low), 12'h018, "busy time");
  endtask
  // strobe that must be ignored
  task automatic strobe();
    cv_n = 1'b0;
    cyc(2);
    cv_n = 1'b1;
    cyc(6);
    chk({11'h000, busy_n}, 12'h001, "ignored start");
  endtask
  // byte select settles a cycle before the read strobe
  task automatic rd(input logic u, input logic [11:0] exp_d, input logic [11:0] exp_oe);
    ubs = u;
    cyc(1);
    rd_n = 1'b0;
    cyc(4);
    chk(data_oe, exp_oe, "drive");
    chk(data_out & exp_oe, exp_d, "data");
    rd_n = 1'b1;
    cyc(4);
    chk(data_oe, 12'h000, "release");
  endtask
  task automatic t_word();
    convert(12'hA5C);
    rd(1'b0, 12'hA5C, 12'hFFF);
    rd(1'b0, 12'hA5C, 12'hFFF);
    rd_n = 1'b0;
    convert(12'h3C3);
    chk(data_out, 12'h3C3, "data at busy rise");
    rd_n = 1'b1;
    cyc(4);
    bip = 1'b1;
    convert(12'h7FF);
    rd(1'b0, 12'hFFF, 12'hFFF);
    convert(12'h800);
    rd(1'b0, 12'h000, 12'hFFF);
    $display("word test done");
  endtask
  task automatic t_bytes();
    two_b = 1'b1;
    convert(12'h7FF);
    rd(1'b1, 12'h007, 12'h0FF);
    rd(1'b0, 12'h0FF, 12'h0FF);
    bip = 1'b0;
    convert(12'h3C5);
    rd(1'b1, 12'h003, 12'h0FF);
    rd(1'b0, 12'h0C5, 12'h0FF);
    two_b = 1'b0;
    $display("byte test done");
  endtask
  // deselected strobes, then a second strobe inside a conversion
  task automatic t_gate();
    cs_n = 1'b1;
    strobe();
    rd_n = 1'b0;
    cyc(5);
    chk(data_oe, 12'h000, "deselected read");
    rd_n = 1'b1;
    level = 12'h5A5;
    cs_n = 1'b0;
    cyc(1);
    cv_n = 1'b0;
    cyc(2);
    cv_n = 1'b1;
    cyc(10);
    cv_n = 1'b0;
    cyc(2);
    cv_n = 1'b1;
    cyc(18);
    chk({11'h000, busy_n}, 12'h001, "no restart");
    rd(1'b0, 12'h5A5, 12'hFFF);
    $display("gate test done");
  endtask
  task automatic t_power();
    sleep_n = 1'b0;
    cyc(5);
    chk({10'h000, reference_ready, sleep_pwrdn}, 12'h001, "sleep");
    strobe();
    sleep_n = 1'b1;
    cyc(2);
    chk({11'h000, reference_ready}, 12'h000, "settling");
    for (int i = 0; i < 30 && !reference_ready; i++) cyc(1);
    chk({11'h000, reference_ready}, 12'h001, "ready");
    nap_n = 1'b0;
    cyc(5);
    chk({10'h000, reference_ready, nap_pwrdn}, 12'h003, "nap");
    strobe();
    nap_n = 1'b1;
    cyc(25); // nap wake-up time before the next start
    convert(12'hFFF);
    rd(1'b0, 12'hFFF, 12'hFFF);
    $display("power test done");
  endtask
  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  // reset for 16 cycles, wait for the reference, run the tests
  initial begin
    cyc(16);
    rstn = 1'b1;
    for (int i = 0; i < 40 && !reference_ready; i++) cyc(1);
    chk({11'h000, reference_ready}, 12'h001, "ready after reset");
    t_word();
    t_bytes();
    t_gate();
    t_power();
    wrap_up();
  end
  // watchdog: the run needs well under 2000 cycles
  initial begin
    #(25 * 5000);
    n_errors++;
    $display("CHECK FAILED watchdog expected finish seen timeout");
    wrap_up();
  end
endmodule
